//--- design/svil_pkg.sv
// Package for the servo input interlock: register map, fields, codes and types
package svil_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ASSIGN   = 8'h04;
    localparam logic [7:0] REG_STATUS   = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
    localparam logic [7:0] REG_IRQ_EN   = 8'h14;
    localparam logic [7:0] REG_CMD      = 8'h18;

    // Control and command register field positions
    localparam int CTRL_DOG_POL  = 0;
    localparam int CTRL_AUTO_FWD = 1;
    localparam int CTRL_AUTO_REV = 2;
    localparam int CTRL_STOP_SLW = 3;
    localparam int CTRL_MAP_FWD  = 4;
    localparam int CTRL_MAP_REV  = 5;
    localparam int CMD_FS_CLEAR  = 0;

    // Output assignment fields, one code byte per terminal
    localparam int ASSIGN_A_LSB = 0;
    localparam int ASSIGN_B_LSB = 8;

    // Reset values
    localparam logic [5:0]  CTRL_RESET   = 6'h30;
    localparam logic [15:0] ASSIGN_RESET = 16'h0000;
    localparam logic [2:0]  IRQ_EN_RESET = 3'h0;

    // Assignment and warning codes
    localparam logic [7:0] CODE_NONE        = 8'h00;
    localparam logic [7:0] CODE_WARNING     = 8'h07;
    localparam logic [7:0] CODE_TRAVEL_DONE = 8'h18;
    localparam logic [7:0] WARN_LIMIT       = 8'h63;

    // Interrupt bit positions
    localparam int IRQ_FSTOP = 0;
    localparam int IRQ_FWD   = 1;
    localparam int IRQ_REV   = 2;

    // Discrete inputs travelling together
    typedef struct packed {
        logic forced_stop;
        logic dog;
        logic fwd_limit;
        logic rev_limit;
    } svil_din_t;

    // Interlock state, one-hot
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_FSTOP = 2'b10
    } svil_state_t;

endpackage

//--- design/svil_top.sv
// Servo input interlock: forced stop, dog polarity, travel limits, warning routing
`timescale 1ns/1ps

// Operation
// - An open forced stop input puts the device in forced stop with base off and brake on.
// - While in forced stop, a closed forced stop input lets the state be cleared.
// - By default an off dog input counts as the proximity dog detected.
// - A setting inverts the dog detection polarity.
// - By default a travel limit turning off stops the motor suddenly and holds it servo-locked.
// - Counter-clockwise travel needs the forward limit on, clockwise the reverse limit.
// - A setting selects the stopping method used when a travel limit turns off.
// - A setting can force either or both travel limits internally on.
// - A travel limit not mapped to a terminal is always on, whatever the auto setting.
// - A travel limit off raises warning code 99 and drives the warning output off.
// - The warning output reaches a terminal only once an assignment setting maps it.
// - Assignment code 24 routes the travel completion signal to a terminal.
module svil_top (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Field inputs and positioning status
    input  wire svil_pkg::svil_din_t pins_i,
    input  wire logic              travel_done_i,
    // Drive and motion control
    output logic                   base_off_o,
    output logic                   dyn_brake_o,
    output logic                   sudden_stop_o,
    output logic                   slow_stop_o,
    output logic                   servo_lock_o,
    output logic                   ccw_permit_o,
    output logic                   cw_permit_o,
    output logic                   dog_detected_o,
    // Warning, output terminals and interrupt
    output logic      [7:0]        warn_code_o,
    output logic      [1:0]        out_term_o,
    output logic                   irq_o
);
    import svil_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchroniser

    svil_din_t   sync1;
    svil_din_t   sync2;
    svil_state_t state;
    logic [5:0]  ctrl;
    logic [15:0] assign_reg;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic        fwd_eff;
    logic        rev_eff;
    logic        fwd_eff_q;
    logic        rev_eff_q;
    logic        fs_clear;
    logic        wb_req;
    logic        wb_wr;
    logic [2:0]  next_irq_stat;
    logic [2:0]  events;

    // Two flops; first stage only feeds the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1 <= '1;
            sync2 <= '1;
        end else begin
            sync1 <= pins_i;
            sync2 <= sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Effective travel limits

    // Unmapped limit always on, else pin or auto-on
    always_comb begin
        fwd_eff = !ctrl[CTRL_MAP_FWD] || sync2.fwd_limit || ctrl[CTRL_AUTO_FWD];
        rev_eff = !ctrl[CTRL_MAP_REV] || sync2.rev_limit || ctrl[CTRL_AUTO_REV];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Forced stop state machine

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_FSTOP;
        end else begin
            case (state)
                ST_RUN: begin
                    if (!sync2.forced_stop) begin
                        state <= ST_FSTOP;
                    end
                end
                ST_FSTOP: begin
                    if (sync2.forced_stop && fs_clear) begin
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_FSTOP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Drive outputs

    // Stop, lock and permit decisions, registered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_off_o    <= 1'b1;
            dyn_brake_o   <= 1'b1;
            sudden_stop_o <= 1'b0;
            slow_stop_o   <= 1'b0;
            servo_lock_o  <= 1'b0;
            ccw_permit_o  <= 1'b0;
            cw_permit_o   <= 1'b0;
        end else begin
            base_off_o    <= state == ST_FSTOP;
            dyn_brake_o   <= state == ST_FSTOP;
            sudden_stop_o <= state == ST_RUN && !(fwd_eff && rev_eff)
                             && !ctrl[CTRL_STOP_SLW];
            slow_stop_o   <= state == ST_RUN && !(fwd_eff && rev_eff)
                             && ctrl[CTRL_STOP_SLW];
            servo_lock_o  <= state == ST_RUN && !(fwd_eff && rev_eff);
            ccw_permit_o  <= state == ST_RUN && fwd_eff;
            cw_permit_o   <= state == ST_RUN && rev_eff;
        end
    end

    // Dog detection with selectable polarity
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dog_detected_o <= 1'b0;
        end else begin
            dog_detected_o <= ctrl[CTRL_DOG_POL] ? sync2.dog : !sync2.dog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Warning and output terminal routing

    // Terminal source from its assignment code
    function automatic logic route(input logic [7:0] code, input logic warn_n,
                                   input logic done);
        case (code)
            CODE_WARNING:     route = warn_n;
            CODE_TRAVEL_DONE: route = done;
            default:          route = 1'b0;
        endcase
    endfunction

    // Warning code and terminals
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_code_o <= 8'h00;
            out_term_o  <= 2'b00;
        end else begin
            warn_code_o   <= (fwd_eff && rev_eff) ? 8'h00 : WARN_LIMIT;
            out_term_o[0] <= route(assign_reg[ASSIGN_A_LSB +: 8], fwd_eff && rev_eff,
                                   travel_done_i);
            out_term_o[1] <= route(assign_reg[ASSIGN_B_LSB +: 8], fwd_eff && rev_eff,
                                   travel_done_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Limit falling edges and forced stop entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_eff_q <= 1'b1;
            rev_eff_q <= 1'b1;
        end else begin
            fwd_eff_q <= fwd_eff;
            rev_eff_q <= rev_eff;
        end
    end

    // Sticky status, set wins over clear
    always_comb begin
        events[IRQ_FSTOP] = state == ST_RUN && !sync2.forced_stop;
        events[IRQ_FWD]   = fwd_eff_q && !fwd_eff;
        events[IRQ_REV]   = rev_eff_q && !rev_eff;
        next_irq_stat     = irq_stat;
        if (wb_wr && wb_adr_i == REG_IRQ_CLR && wb_sel_i[0]) begin
            next_irq_stat = irq_stat & ~wb_dat_i[2:0];
        end
        next_irq_stat = next_irq_stat | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 3'h0;
            irq_o    <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_o    <= |(next_irq_stat & irq_en);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone slave

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_req && wb_we_i;

    // One-wait-state acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= CTRL_RESET;
            assign_reg <= ASSIGN_RESET;
            irq_en     <= IRQ_EN_RESET;
            fs_clear   <= 1'b0;
        end else begin
            fs_clear <= wb_wr && wb_adr_i == REG_CMD && wb_sel_i[0]
                        && wb_dat_i[CMD_FS_CLEAR];
            if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
                ctrl <= wb_dat_i[5:0];
            end
            if (wb_wr && wb_adr_i == REG_ASSIGN) begin
                if (wb_sel_i[0]) begin
                    assign_reg[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    assign_reg[15:8] <= wb_dat_i[15:8];
                end
            end
            if (wb_wr && wb_adr_i == REG_IRQ_EN && wb_sel_i[0]) begin
                irq_en <= wb_dat_i[2:0];
            end
        end
    end

    // Read data; unmapped and write-only read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                REG_CTRL:     wb_dat_o <= {26'h000_0000, ctrl};
                REG_ASSIGN:   wb_dat_o <= {16'h0000, assign_reg};
                REG_STATUS:   wb_dat_o <= {16'h0000, warn_code_o, 1'b0,
                                           state == ST_FSTOP, dog_detected_o,
                                           fwd_eff, rev_eff, sync2.forced_stop,
                                           ccw_permit_o, cw_permit_o};
                REG_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_stat};
                REG_IRQ_EN:   wb_dat_o <= {29'h0000_0000, irq_en};
                default:      wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_fs_open;
        state == ST_RUN && !sync2.forced_stop;
    endsequence

    sequence s_fs_shut;
        state == ST_FSTOP ##1 base_off_o && dyn_brake_o;
    endsequence

    a_fstop_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_fs_open |=> s_fs_shut) else $error("forced stop not entered");

    a_fstop_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_FSTOP && !sync2.forced_stop |=> state == ST_FSTOP)
        else $error("forced stop left while input open");

    a_fstop_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_FSTOP && sync2.forced_stop && fs_clear |=> state == ST_RUN ##1 !base_off_o)
        else $error("forced stop not cleared");

    a_dog_polarity: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 dog_detected_o == ($past(sync2.dog) ~^ $past(ctrl[CTRL_DOG_POL])))
        else $error("dog detection polarity wrong");

    a_limit_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_RUN && !fwd_eff && !ctrl[CTRL_STOP_SLW]
        |=> sudden_stop_o && servo_lock_o && !slow_stop_o && !ccw_permit_o)
        else $error("limit stop wrong");

    a_rev_permit: assert property (@(posedge clk_i) disable iff (rst_i)
        state == ST_RUN && !rev_eff |=> !cw_permit_o && warn_code_o == WARN_LIMIT)
        else $error("reverse limit not honoured");

    a_unmapped_on: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl[CTRL_MAP_FWD] |-> fwd_eff)
        else $error("unmapped limit not on");

    a_travel_route: assert property (@(posedge clk_i) disable iff (rst_i)
        assign_reg[ASSIGN_B_LSB +: 8] == CODE_TRAVEL_DONE |=> out_term_o[1] == $past(travel_done_i))
        else $error("travel done not routed");

    a_warn_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        assign_reg[ASSIGN_A_LSB +: 8] == CODE_NONE |=> !out_term_o[0])
        else $error("terminal driven unassigned");

endmodule

//--- testbench/svil_field_model.sv
// Field wiring model: switches and sensors wired to the interlock inputs
`timescale 1ns/1ps
module svil_field_model (
    // Clock
    input  wire logic                clk_i,
    // Switch levels requested by the bench
    input  wire svil_pkg::svil_din_t want_i,
    // Wiring into the device
    output svil_pkg::svil_din_t      pins_o
);
    import svil_pkg::*;

    // Forced stop contact starts closed, dog off, limits on, before operation begins
    initial begin
        pins_o = 4'hB;
    end

    // Contacts move just after a clock edge
    always @(posedge clk_i) begin
        pins_o <= want_i;
    end
endmodule

//--- testbench/test_servo_input_interlock.sv
// Self-checking bench for the servo input interlock
`timescale 1ns/1ps
module test_servo_input_interlock;
    import svil_pkg::*;

    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        wb_we_i = 1'h0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    svil_din_t   want = 4'hB;
    svil_din_t   pins;
    logic        travel_done_i = 1'h0;
    logic        base_off_o, dyn_brake_o, sudden_stop_o, slow_stop_o, servo_lock_o;
    logic        ccw_permit_o, cw_permit_o, dog_detected_o, irq_o;
    logic [7:0]  warn_code_o;
    logic [1:0]  out_term_o;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          n_cycle = 0;
    int          seed;
    logic [31:0] r;
    logic        fe, re, off;

    // Clock, 50 ns period
    always #25 clk_i = ~clk_i;

    svil_field_model u_field (.clk_i(clk_i), .want_i(want), .pins_o(pins));

    svil_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_i(pins),
        .travel_done_i(travel_done_i), .base_off_o(base_off_o), .dyn_brake_o(dyn_brake_o),
        .sudden_stop_o(sudden_stop_o), .slow_stop_o(slow_stop_o),
        .servo_lock_o(servo_lock_o), .ccw_permit_o(ccw_permit_o),
        .cw_permit_o(cw_permit_o), .dog_detected_o(dog_detected_o),
        .warn_code_o(warn_code_o), .out_term_o(out_term_o), .irq_o(irq_o)
    );

    // Verdict and end of run
    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Comparisons
    task automatic chk_bit(input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask

    // Classic Wishbone single cycle, held until ack is sampled
    task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 50);
        rd = wb_dat_o;
        chk_bit(1'h1, wb_ack_o);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i  <= 1'h0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
        logic [31:0] x;
        wb_rw(1'h1, adr, sel, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] e);
        logic [31:0] x;
        wb_rw(1'h0, adr, 4'hF, 32'h0000_0000, x);
        chk_word(e, x);
    endtask

    // Lets field model, synchroniser, state and output stages land
    task automatic settle;
        repeat (6) @(posedge clk_i);
    endtask

    // Effective limit level after mapping and auto-on
    function automatic logic eff(input logic pin, input logic auto_on, input logic mapped);
        return !mapped || auto_on || pin;
    endfunction

    // Hang guard
    always @(posedge clk_i) begin
        n_cycle <= n_cycle + 1;
        if (n_cycle == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        seed = 34564;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk_bit(1'h1, base_off_o);
        chk_bit(1'h1, dyn_brake_o);
        rd_chk(REG_CTRL, 32'h0000_0030);
        rd_chk(REG_ASSIGN, 32'h0000_0000);
        rd_chk(REG_IRQ_EN, 32'h0000_0000);
        rd_chk(8'h40, 32'h0000_0000);
        chk_word(32'h0000_0000, {30'h0, out_term_o});
        wr(REG_CMD, 4'h1, 32'h0000_0001);
        settle();
        chk_bit(1'h0, base_off_o);
        chk_bit(1'h0, dyn_brake_o);
        // Random limits, dog level and settings
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            want.fwd_limit <= r[0];
            want.rev_limit <= r[1];
            want.dog <= r[2];
            travel_done_i <= r[3];
            wr(REG_CTRL, 4'h1, {26'h0, r[9:4]});
            wr(REG_ASSIGN, 4'h3, 32'h0000_1807);
            settle();
            fe = eff(r[0], r[5], r[8]);
            re = eff(r[1], r[6], r[9]);
            off = !(fe && re);
            chk_bit(fe, ccw_permit_o);
            chk_bit(re, cw_permit_o);
            chk_word(off ? 32'h0000_0063 : 32'h0000_0000, {24'h0, warn_code_o});
            chk_bit(off && !r[7], sudden_stop_o);
            chk_bit(off && r[7], slow_stop_o);
            if (!r[7]) chk_bit(off, servo_lock_o);
            chk_bit(r[4] ? r[2] : !r[2], dog_detected_o);
            chk_word({30'h0, r[3], !off}, {30'h0, out_term_o});
        end
        // Interrupt raised, kept sticky, masked and cleared
        want.fwd_limit <= 1'h1;
        want.rev_limit <= 1'h1;
        wr(REG_CTRL, 4'h1, 32'h0000_0030);
        settle();
        wr(REG_IRQ_CLR, 4'h1, 32'h0000_0007);
        wr(REG_IRQ_EN, 4'h1, 32'h0000_0002);
        settle();
        chk_bit(1'h0, irq_o);
        want.fwd_limit <= 1'h0;
        settle();
        chk_bit(1'h1, irq_o);
        rd_chk(REG_IRQ_STAT, 32'h0000_0002);
        want.fwd_limit <= 1'h1;
        wr(REG_IRQ_EN, 4'h1, 32'h0000_0000);
        settle();
        chk_bit(1'h0, irq_o);
        wr(REG_IRQ_EN, 4'h1, 32'h0000_0002);
        settle();
        chk_bit(1'h1, irq_o);
        wr(REG_IRQ_CLR, 4'h1, 32'h0000_0002);
        settle();
        chk_bit(1'h0, irq_o);
        // Forced stop entry, refused clear, then clear
        want.forced_stop <= 1'h0;
        settle();
        chk_bit(1'h1, base_off_o);
        chk_bit(1'h1, dyn_brake_o);
        rd_chk(REG_IRQ_STAT, 32'h0000_0001);
        rd_chk(REG_STATUS, {24'h0, 2'b01, !want.dog, 2'b11, 3'b000});
        wr(REG_CMD, 4'h1, 32'h0000_0001);
        settle();
        chk_bit(1'h1, base_off_o);
        want.forced_stop <= 1'h1;
        settle();
        chk_bit(1'h1, base_off_o);
        wr(REG_CMD, 4'h1, 32'h0000_0001);
        settle();
        chk_bit(1'h0, base_off_o);
        chk_bit(1'h1, ccw_permit_o);
        end_sim();
    end
endmodule
